// file: hdl/failure_prediction_cmd.v
// failure-prediction command handler on the task-file port
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "fp_cmd_map.vh"
module failure_prediction_cmd #(
    parameter [39:0] AUTOSAVE_PERIOD = `AUTOSAVE_CYC
) (
    input  wire        clk_sys,
    input  wire        rst_b,
    // task-file register port
    input  wire [9:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata,
    // nonvolatile store
    input  wire [1:0]  nv_load_data,
    input  wire        nv_load_valid,
    output wire        nv_write,
    output wire [1:0]  nv_write_data,
    // attribute engine
    output wire        collect_en,
    output reg         save_req,
    input  wire        save_done,
    input  wire        threshold_exceeded,
    output reg  [1:0]  block_sel,
    output reg  [8:0]  block_addr,
    input  wire [7:0]  block_byte,
    // host interrupt
    output reg         intrq
);
    // ====================================================
    // state machine codes
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_SAVE  = 3'd1;
    localparam [2:0] S_WAIT  = 3'd2;
    localparam [2:0] S_XFER  = 3'd3;
    localparam [2:0] S_DONE  = 3'd4;
    localparam [2:0] S_FETCH = 3'd5;

    reg [7:0] subcommand_select;
    reg [7:0] sector_count_param;
    reg [7:0] sector_number_param;
    reg [7:0] key_low;
    reg [7:0] key_high;
    reg [7:0] drive_head_select;
    reg [7:0] error_reg;
    reg       busy;
    reg       drq;
    reg       err;
    reg [2:0] state;
    reg [7:0] active_sub;
    reg [9:0] xfer_count;
    reg [7:0] data_latch;
    reg       auto_save;

    wire [1:0] settings;
    wire       feature_on  = settings[`NV_FEATURE_BIT];
    wire       autosave_on = settings[`NV_AUTOSAVE_BIT];
    reg        set_feature;
    reg        feature_val;
    reg        set_autosave;
    wire       tick;

    wire cmd_wr   = wr && (addr == `ADDR_CMD) && !busy && !drq;
    wire data_rd  = rd && (addr == 10'h1f0) && drq;
    wire keys_ok  = (key_low == `KEY_LOW_OK) && (key_high == `KEY_HIGH_OK);
    wire sub_known = (subcommand_select == `SUB_READ_ATTR) ||
                     (subcommand_select == `SUB_READ_THR)  ||
                     (subcommand_select == `SUB_AUTOSAVE)  ||
                     (subcommand_select == `SUB_SAVE)      ||
                     (subcommand_select == `SUB_ENABLE)    ||
                     (subcommand_select == `SUB_DISABLE)   ||
                     (subcommand_select == `SUB_STATUS);
    wire allowed  = feature_on || (subcommand_select == `SUB_ENABLE);
    wire [7:0] status = {busy, !busy, 2'b01, drq, 2'b00, err};

    assign collect_en = feature_on; // [R05]

    // ====================================================
    // persistent settings and periodic save
    nv_settings u_nv (
        .clk_sys       (clk_sys),
        .rst_b         (rst_b),
        .nv_load_data  (nv_load_data),
        .nv_load_valid (nv_load_valid),
        .set_feature   (set_feature),
        .feature_val   (feature_val),
        .set_autosave  (set_autosave),
        .autosave_val  (sector_count_param != 8'h00), // [R08]
        .settings      (settings),
        .nv_write      (nv_write),
        .nv_write_data (nv_write_data)
    );

    autosave_timer #(.PERIOD(AUTOSAVE_PERIOD)) u_timer (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .run     (autosave_on && feature_on), // [R11]
        .restart (save_req),
        .tick    (tick)
    );

    // ====================================================
    // register reads, one cycle latency
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                10'h1f0:        rdata <= drq ? data_latch : 8'h00;
                `ADDR_SUBCMD:   rdata <= error_reg;
                `ADDR_SECCNT:   rdata <= sector_count_param;
                `ADDR_SECNUM:   rdata <= sector_number_param;
                `ADDR_KEY_LOW:  rdata <= key_low;
                `ADDR_KEY_HIGH: rdata <= key_high;
                `ADDR_DRVHEAD:  rdata <= drive_head_select;
                `ADDR_CMD:      rdata <= status;
                default:        rdata <= 8'h00;
            endcase
        end
    end

    // ====================================================
    // command sequencer and task-file registers
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            subcommand_select   <= 8'h00;
            sector_count_param  <= 8'h00;
            sector_number_param <= 8'h00;
            key_low             <= 8'h00;
            key_high            <= 8'h00;
            drive_head_select   <= 8'h00;
            error_reg           <= 8'h00;
            busy                <= 1'b0;
            drq                 <= 1'b0;
            err                 <= 1'b0;
            intrq               <= 1'b0;
            state               <= S_IDLE;
            active_sub          <= 8'h00;
            xfer_count          <= 10'h0;
            data_latch          <= 8'h00;
            save_req            <= 1'b0;
            auto_save           <= 1'b0;
            block_sel           <= 2'h0;
            block_addr          <= 9'h0;
            set_feature         <= 1'b0;
            feature_val         <= 1'b0;
            set_autosave        <= 1'b0;
        end else begin
            set_feature  <= 1'b0;
            set_autosave <= 1'b0;
            save_req     <= 1'b0;
            // status read clears the interrupt
            if (rd && addr == `ADDR_CMD) begin
                intrq <= 1'b0;
            end
            // host writes land only when not busy
            if (wr && !busy) begin
                case (addr)
                    `ADDR_SUBCMD:   subcommand_select   <= wdata;
                    `ADDR_SECCNT:   sector_count_param  <= wdata;
                    `ADDR_SECNUM:   sector_number_param <= wdata;
                    `ADDR_KEY_LOW:  key_low             <= wdata;
                    `ADDR_KEY_HIGH: key_high            <= wdata;
                    `ADDR_DRVHEAD:  drive_head_select   <= wdata;
                    default:        ;
                endcase
            end
            case (state)
                S_IDLE, S_SAVE: begin
                    if (cmd_wr) begin
                        intrq      <= 1'b0;
                        active_sub <= subcommand_select;
                        err        <= 1'b0;
                        error_reg  <= 8'h00;
                        if (wdata != `CMD_FAIL_PRED) begin // [R01]
                            err       <= 1'b1;
                            error_reg <= 8'h04;
                            intrq     <= 1'b1;
                        end else if (!keys_ok || !sub_known || !allowed) begin // [R03] [R04] [R20]
                            err       <= 1'b1;
                            error_reg <= 8'h04;
                            intrq     <= 1'b1; // [R21]
                        end else begin
                            busy <= 1'b1;
                            case (subcommand_select) // [R01]
                                `SUB_READ_ATTR, `SUB_SAVE, `SUB_STATUS: begin
                                    save_req <= 1'b1; // [R06] [R12] [R15]
                                    state    <= S_WAIT;
                                end
                                `SUB_READ_THR: begin
                                    block_sel  <= 2'h1; // [R07]
                                    block_addr <= 9'h0;
                                    xfer_count <= 10'h0;
                                    state      <= S_FETCH;
                                end
                                `SUB_AUTOSAVE: begin
                                    set_autosave <= 1'b1; // [R08]
                                    state        <= S_DONE;
                                end
                                `SUB_ENABLE: begin
                                    set_feature <= 1'b1; // [R13]
                                    feature_val <= 1'b1;
                                    state       <= S_DONE;
                                end
                                `SUB_DISABLE: begin
                                    set_feature <= 1'b1; // [R14]
                                    feature_val <= 1'b0;
                                    state       <= S_DONE;
                                end
                                default: state <= S_DONE;
                            endcase
                        end
                    end else if (tick && feature_on) begin
                        save_req  <= 1'b1; // [R10] [R11]
                        auto_save <= 1'b1;
                        state     <= S_SAVE;
                    end else if (state == S_SAVE && save_done) begin
                        // background autosave, host not involved
                        auto_save <= 1'b0;
                        state     <= S_IDLE;
                    end
                end
                S_WAIT: begin
                    if (save_done) begin
                        if (active_sub == `SUB_STATUS) begin
                            key_low  <= threshold_exceeded ? `KEY_LOW_BAD : `KEY_LOW_OK; // [R15] [R16]
                            key_high <= threshold_exceeded ? `KEY_HIGH_BAD : `KEY_HIGH_OK;
                            state    <= S_DONE; // [R17]
                        end else if (active_sub == `SUB_READ_ATTR) begin
                            block_sel  <= 2'h0; // [R06]
                            block_addr <= 9'h0;
                            xfer_count <= 10'h0;
                            state      <= S_FETCH;
                        end else begin
                            state <= S_DONE;
                        end
                    end
                end
                S_FETCH: begin
                    // block byte is ready one cycle after its address
                    data_latch <= block_byte;
                    busy       <= 1'b0;
                    drq        <= 1'b1;
                    if (xfer_count == 10'h0) begin
                        intrq <= 1'b1; // [R21]
                    end
                    state <= S_XFER;
                end
                S_XFER: begin
                    if (data_rd) begin
                        xfer_count <= xfer_count + 10'h1;
                        if (xfer_count == `BLOCK_BYTES - 10'h1) begin
                            drq   <= 1'b0;
                            state <= S_IDLE;
                        end else begin
                            drq        <= 1'b0;
                            busy       <= 1'b1;
                            block_addr <= block_addr + 9'h1;
                            state      <= S_FETCH;
                        end
                    end
                end
                S_DONE: begin
                    busy  <= 1'b0;
                    intrq <= 1'b1; // [R21]
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // failure_prediction_cmd

// file: hdl/fp_cmd_map.vh
// constants for the failure-prediction command handler
// =====================================================
// Summary of operation
// [R01] command b0 starts failure prediction; subcommand from subcommand_select
// [R02] host loads key_low 4f and key_high c2 before the command
// [R03] wrong key in key_low or key_high aborts the command
// [R04] feature disabled: every subcommand except d8 aborts
// [R05] feature enabled: attribute collection keeps running
// [R06] d0: busy, save attributes, clear busy, send 512-byte attribute block
// [R07] d1: send 512-byte threshold block
// [R08] d2: busy, autosave on if sector count nonzero else off, clear busy
// [R09] autosave setting kept in nonvolatile store
// [R10] autosave: save attributes every 15 minutes since last save
// [R11] no autosave while feature disabled
// [R12] d3: busy, write attributes to medium, clear busy
// [R13] d8: busy, enable feature persistently, clear busy
// [R14] d9: busy, disable feature persistently, clear busy
// [R15] da: busy, save, compare; exceeded gives key_low f4, key_high 2c
// [R16] da with nothing exceeded gives key_low 4f, key_high c2
// [R17] da clears busy only after the key registers settle
// [R18] host issues d0, d3 or da regularly unless autosave on
// [R19] host should poll da and inspect key registers
// [R20] undefined subcommand values abort
// [R21] interrupt request raised after busy clears
`ifndef FP_CMD_MAP_VH
`define FP_CMD_MAP_VH
// task-file offsets
`define ADDR_SUBCMD      10'h1f1
`define ADDR_SECCNT      10'h1f2
`define ADDR_SECNUM      10'h1f3
`define ADDR_KEY_LOW     10'h1f4
`define ADDR_KEY_HIGH    10'h1f5
`define ADDR_DRVHEAD     10'h1f6
`define ADDR_CMD         10'h1f7
// codes
`define CMD_FAIL_PRED    8'hb0
`define SUB_READ_ATTR    8'hd0
`define SUB_READ_THR     8'hd1
`define SUB_AUTOSAVE     8'hd2
`define SUB_SAVE         8'hd3
`define SUB_ENABLE       8'hd8
`define SUB_DISABLE      8'hd9
`define SUB_STATUS       8'hda
`define KEY_LOW_OK       8'h4f
`define KEY_HIGH_OK      8'hc2
`define KEY_LOW_BAD      8'hf4
`define KEY_HIGH_BAD     8'h2c
// status and error bits
`define ST_BSY           7
`define ST_DRDY          6
`define ST_DRQ           3
`define ST_ERR           0
`define ER_ABRT          2
// block size and timing
`define BLOCK_BYTES      10'd512
`define CLK_HZ           200000000
`define AUTOSAVE_MIN     15
`define AUTOSAVE_CYC     (`AUTOSAVE_MIN * 40'd60 * `CLK_HZ)
`define NV_FEATURE_BIT   0
`define NV_AUTOSAVE_BIT  1
`endif

// file: hdl/autosave_timer.v
// periodic autosave tick generator
`timescale 1ns/1ps
`include "fp_cmd_map.vh"
module autosave_timer #(
    parameter [39:0] PERIOD = `AUTOSAVE_CYC
) (
    input  wire clk_sys,
    input  wire rst_b,
    input  wire run,
    input  wire restart,
    output reg  tick
);
    reg [39:0] count;
    // count from the last save; a manual save restarts the interval
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count <= 40'h0;
            tick  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (restart || !run) begin
                count <= 40'h0; // [R11]
            end else if (count >= PERIOD - 40'h1) begin
                count <= 40'h0;
                tick  <= 1'b1; // [R10]
            end else begin
                count <= count + 40'h1;
            end
        end
    end
endmodule // autosave_timer

// file: hdl/nv_settings.v
// nonvolatile settings store, loaded at power-up and written on change
`timescale 1ns/1ps
`include "fp_cmd_map.vh"
module nv_settings (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [1:0] nv_load_data,
    input  wire       nv_load_valid,
    input  wire       set_feature,
    input  wire       feature_val,
    input  wire       set_autosave,
    input  wire       autosave_val,
    output reg  [1:0] settings,
    output reg        nv_write,
    output reg  [1:0] nv_write_data
);
    // hold current settings; every change is pushed to the store
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            settings      <= 2'h0;
            nv_write      <= 1'b0;
            nv_write_data <= 2'h0;
        end else begin
            nv_write <= set_feature | set_autosave;
            if (nv_load_valid) begin
                settings <= nv_load_data;
            end else begin
                if (set_feature) begin
                    settings[`NV_FEATURE_BIT] <= feature_val; // [R13] [R14]
                end
                if (set_autosave) begin
                    settings[`NV_AUTOSAVE_BIT] <= autosave_val; // [R09]
                end
            end
            nv_write_data <= {set_autosave ? autosave_val : settings[`NV_AUTOSAVE_BIT],
                              set_feature ? feature_val : settings[`NV_FEATURE_BIT]};
        end
    end
endmodule // nv_settings

// file: tb/fp_checker.sv
// assertion checker bound to the failure-prediction command handler
`timescale 1ns/1ps
`include "fp_cmd_map.vh"
module fp_checker #(
    parameter [39:0] AUTOSAVE_PERIOD = `AUTOSAVE_CYC
) (
    input wire       clk_sys,
    input wire       rst_b,
    input wire [9:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       collect_en,
    input wire       save_req,
    input wire       save_done,
    input wire       nv_write,
    input wire [1:0] nv_write_data,
    input wire       intrq
);
    // ====================================================
    // shadow of the command parameters
    reg  [7:0] kl, kh, fr;
    wire       cmd = wr && addr == `ADDR_CMD && wdata == `CMD_FAIL_PRED;
    wire       ok = cmd && kl == `KEY_LOW_OK && kh == `KEY_HIGH_OK;
    wire       sv = fr == `SUB_READ_ATTR || fr == `SUB_SAVE || fr == `SUB_STATUS;
    wire       nd = fr == `SUB_AUTOSAVE || fr == `SUB_ENABLE || fr == `SUB_DISABLE;
    wire       quiet = !save_req && !nv_write;
    // track key and subcommand writes
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            kl <= 8'h00;
            kh <= 8'h00;
            fr <= 8'h00;
        end else if (wr && addr == `ADDR_KEY_LOW) begin
            kl <= wdata;
        end else if (wr && addr == `ADDR_KEY_HIGH) begin
            kh <= wdata;
        end else if (wr && addr == `ADDR_SUBCMD) begin
            fr <= wdata;
        end
    end
    // ====================================================
    // properties
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    a_key_abort:
        assert property (cmd && !ok |=> quiet [*4]) else $error("bad key not aborted");
    a_off_abort:
        assert property (ok && !collect_en && fr != `SUB_ENABLE |=> quiet [*4])
        else $error("ran while disabled");
    a_undef_abort:
        assert property (ok && !sv && !nd && fr != `SUB_READ_THR |=> quiet [*4])
        else $error("unknown sub acted");
    a_save_start:
        assert property (ok && collect_en && sv |-> ##[1:3] save_req)
        else $error("no attribute save");
    a_enable_store:
        assert property (ok && !collect_en && fr == `SUB_ENABLE |-> ##[1:3]
            (nv_write && nv_write_data[0])) else $error("enable not stored");
    a_disable_store:
        assert property (ok && collect_en && fr == `SUB_DISABLE |-> ##[1:3]
            (nv_write && !nv_write_data[0])) else $error("disable not stored");
    a_done_irq:
        assert property (ok && !collect_en && fr == `SUB_ENABLE |=> !intrq ##[1:3] intrq)
        else $error("no irq after enable");
    a_nv_follow:
        assert property (nv_write |=> collect_en == $past(nv_write_data[0]))
        else $error("collect differs from store");
    a_no_auto_off:
        assert property (save_req |-> collect_en) else $error("save while disabled");
    c_status: cover property (ok && fr == `SUB_STATUS);
    c_done: cover property (save_done && !save_req);
    c_nv_both: cover property (nv_write && nv_write_data == 2'b11);
endmodule // fp_checker

bind failure_prediction_cmd fp_checker #(.AUTOSAVE_PERIOD(AUTOSAVE_PERIOD)) chk_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .collect_en(collect_en), .save_req(save_req), .save_done(save_done),
    .nv_write(nv_write), .nv_write_data(nv_write_data), .intrq(intrq)
);

// file: tb/attr_engine_model.sv
// attribute engine model: saves, block bytes, verdict
`timescale 1ns/1ps
module attr_engine_model (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        save_req,
    input  wire        slow,
    input  wire        exceed,
    input  wire [1:0]  block_sel,
    input  wire [8:0]  block_addr,
    output reg         save_done,
    output wire        threshold_exceeded,
    output wire [7:0]  block_byte,
    output reg  [15:0] saves
);
    reg [5:0] wait_cnt;
    reg       busy;
    assign threshold_exceeded = exceed;
    assign block_byte = block_addr[7:0] ^ {block_addr[8], block_sel, 5'h0a};
    // a save takes 3 or 21 cycles
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            wait_cnt <= 6'h00;
            save_done <= 1'b0;
            saves <= 16'h0000;
        end else begin
            save_done <= 1'b0;
            if (save_req) begin
                busy <= 1'b1;
                wait_cnt <= slow ? 6'h14 : 6'h02;
            end else if (busy && wait_cnt == 6'h00) begin
                busy <= 1'b0;
                save_done <= 1'b1;
                saves <= saves + 16'h0001;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 6'h01;
            end
        end
    end
endmodule // attr_engine_model

// file: tb/failure_prediction_cmd_test.sv
// self-checking bench for the failure-prediction command handler
`timescale 1ns/1ps
`include "fp_cmd_map.vh"
module failure_prediction_cmd_test;
    reg         clk_sys, rst_b, wr, rd, nv_load_valid, slow, exceed;
    reg  [9:0]  addr;
    reg  [7:0]  wdata, rv;
    reg  [1:0]  nv_load_data, nv_seen;
    reg  [15:0] base;
    wire        nv_write, collect_en, save_req, save_done, threshold_exceeded, intrq;
    wire [7:0]  rdata, block_byte;
    wire [1:0]  nv_write_data, block_sel;
    wire [8:0]  block_addr;
    wire [15:0] saves;
    integer     mismatches, n_compared, i;
    failure_prediction_cmd #(.AUTOSAVE_PERIOD(40'd100)) dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .nv_load_data(nv_load_data), .nv_load_valid(nv_load_valid),
        .nv_write(nv_write), .nv_write_data(nv_write_data), .collect_en(collect_en),
        .save_req(save_req), .save_done(save_done), .threshold_exceeded(threshold_exceeded),
        .block_sel(block_sel), .block_addr(block_addr), .block_byte(block_byte), .intrq(intrq));
    attr_engine_model eng_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .save_req(save_req), .slow(slow), .exceed(exceed),
        .block_sel(block_sel), .block_addr(block_addr), .save_done(save_done),
        .threshold_exceeded(threshold_exceeded), .block_byte(block_byte), .saves(saves));
    // ====================================================
    // clock, store monitor and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (nv_write) nv_seen <= nv_write_data;
    initial begin
        #400000;
        mismatches = mismatches + 1;
        final_report;
    end
    // ====================================================
    // bus tasks and comparison
    task chk(input [63:0] what, input [7:0] exp, input [7:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr_reg(input [9:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk_sys);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [9:0] a);
        begin
            @(posedge clk_sys);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk_sys);
            rd <= 1'b0;
            #1 rv = rdata;
        end
    endtask
    task poll(input [7:0] mask, input [7:0] want);
        integer j;
        begin
            rv = ~want;
            for (j = 0; j < 100 && (rv & mask) !== want; j = j + 1)
                rd_reg(`ADDR_CMD);
            chk("status", want, rv & mask);
        end
    endtask
    task issue(input [7:0] sub, input [7:0] sc, input [7:0] key);
        begin
            wr_reg(`ADDR_SUBCMD, sub);
            wr_reg(`ADDR_SECCNT, sc);
            wr_reg(`ADDR_KEY_LOW, key);
            wr_reg(`ADDR_KEY_HIGH, `KEY_HIGH_OK);
            wr_reg(`ADDR_CMD, `CMD_FAIL_PRED);
        end
    endtask
    // non-data subcommand: interrupt, status, error
    task cmd(input [7:0] sub, input [7:0] sc, input [7:0] key, input [7:0] st);
        begin
            issue(sub, sc, key);
            @(posedge clk_sys);
            for (i = 0; i < 300 && intrq !== 1'b1; i = i + 1)
                @(posedge clk_sys);
            #1 chk("intrq", 8'h01, {7'h00, intrq});
            poll(8'h81, st);
            if (st[0]) begin
                rd_reg(`ADDR_SUBCMD);
                chk("error", 8'h04, rv);
            end
        end
    endtask
    task read_block(input [7:0] sub, input [1:0] sel);
        integer k;
        begin
            issue(sub, 8'h00, `KEY_LOW_OK);
            for (k = 0; k < 512; k = k + 1) begin
                poll(8'h08, 8'h08);
                rd_reg(10'h1f0);
                chk("byte", k[7:0] ^ {k[8], sel, 5'h0a}, rv);
            end
            poll(8'h88, 8'h00);
        end
    endtask
    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // ====================================================
    // test sequence
    initial begin
        rst_b = 1'b0;
        addr = 10'h000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        nv_load_data = 2'b00;
        nv_load_valid = 1'b0;
        slow = 1'b0;
        exceed = 1'b0;
        mismatches = 0;
        n_compared = 0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        nv_load_valid <= 1'b1;
        @(posedge clk_sys);
        nv_load_valid <= 1'b0;
        wr_reg(`ADDR_SECNUM, 8'h5a);
        rd_reg(`ADDR_SECNUM);
        chk("secnum", 8'h5a, rv);
        rd_reg(10'h100);
        chk("unmapped", 8'h00, rv);
        cmd(`SUB_READ_ATTR, 8'h00, `KEY_LOW_OK, 8'h01);
        cmd(`SUB_ENABLE, 8'h00, 8'h00, 8'h01);
        chk("collect", 8'h00, {7'h00, collect_en});
        $display("test disabled done");
        cmd(`SUB_ENABLE, 8'h00, `KEY_LOW_OK, 8'h00);
        chk("collect", 8'h01, {7'h00, collect_en});
        chk("nv", 8'h01, {6'h00, nv_seen});
        cmd(8'hd4, 8'h00, `KEY_LOW_OK, 8'h01);
        base = saves;
        cmd(`SUB_SAVE, 8'h00, `KEY_LOW_OK, 8'h00);
        chk("saves", 8'h01, saves[7:0] - base[7:0]);
        $display("test enable done");
        cmd(`SUB_STATUS, 8'h00, `KEY_LOW_OK, 8'h00);
        rd_reg(`ADDR_KEY_LOW);
        chk("keylow", `KEY_LOW_OK, rv);
        rd_reg(`ADDR_KEY_HIGH);
        chk("keyhigh", `KEY_HIGH_OK, rv);
        exceed = 1'b1;
        slow = 1'b1;
        cmd(`SUB_STATUS, 8'h00, `KEY_LOW_OK, 8'h00);
        rd_reg(`ADDR_KEY_LOW);
        chk("keylow", `KEY_LOW_BAD, rv);
        rd_reg(`ADDR_KEY_HIGH);
        chk("keyhigh", `KEY_HIGH_BAD, rv);
        exceed = 1'b0;
        $display("test status done");
        base = saves;
        read_block(`SUB_READ_ATTR, 2'b00);
        chk("saves", 8'h01, saves[7:0] - base[7:0]);
        slow = 1'b0;
        read_block(`SUB_READ_THR, 2'b01);
        $display("test blocks done");
        cmd(`SUB_AUTOSAVE, 8'h01, `KEY_LOW_OK, 8'h00);
        chk("nv", 8'h03, {6'h00, nv_seen});
        base = saves;
        repeat (250) @(posedge clk_sys);
        chk("autosave", 8'h02, saves[7:0] - base[7:0]);
        cmd(`SUB_AUTOSAVE, 8'h00, `KEY_LOW_OK, 8'h00);
        chk("nv", 8'h01, {6'h00, nv_seen});
        cmd(`SUB_AUTOSAVE, 8'h80, `KEY_LOW_OK, 8'h00);
        cmd(`SUB_DISABLE, 8'h00, `KEY_LOW_OK, 8'h00);
        chk("nv", 8'h02, {6'h00, nv_seen});
        repeat (5) @(posedge clk_sys);
        base = saves;
        repeat (250) @(posedge clk_sys);
        chk("nosave", 8'h00, saves[7:0] - base[7:0]);
        cmd(`SUB_STATUS, 8'h00, `KEY_LOW_OK, 8'h01);
        $display("test autosave done");
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        nv_load_data <= 2'b01;
        nv_load_valid <= 1'b1;
        @(posedge clk_sys);
        nv_load_valid <= 1'b0;
        @(posedge clk_sys);
        chk("collect", 8'h01, {7'h00, collect_en});
        cmd(`SUB_STATUS, 8'h00, `KEY_LOW_OK, 8'h00);
        $display("test power cycle done");
        final_report;
    end
endmodule // failure_prediction_cmd_test
